//--- core/mpt_top.sv
// Match based pwm timer: prescaler, 32-bit counter, seven match
// channels with actions, six pwm pins, interrupt status and mask.
// Assumes one peripheral clock and a register master on the same clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Seven matches drive six pwm outputs
// - Cycle match zeroes counter, sets period
// - Single edge: cycle match plus edge match
// - Single edge outputs rise at cycle start
// - Each extra single edge uses one match
// - Double edge: rise match and fall match
// - Each extra double edge uses two matches
// - Rise before fall positive, else negative
// - Match may just raise an event
// - Match may halt the counter
// - Match may zero the counter
// - Period and width any tick count
// - Released values applied in step with cycle
// - Without pwm mode, plain match timer
// - 32-bit counter behind 32-bit prescaler
// - Counts peripheral clock cycles
// - Only pwm outputs reach pins
module mpt_top (
  input  wire logic            clock_i,   // Peripheral clock, 20 MHz
  input  wire logic            sys_rst_i, // Async reset, high
  input  wire mpt_pkg::mpt_req_s req_i,   // Register request
  output logic          [31:0] rdata_o,   // Read data, cycle after read
  output logic           [5:0] pwm_o,     // Pwm pins, outputs 1 to 6
  output logic                 irq_o      // Level interrupt
);
  import mpt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] count_q;     // Timer counter
  logic [31:0] pre_cnt_q;   // Prescale counter
  logic [31:0] pre_lim_q;   // Prescale limit
  logic        run_q;       // Counter enable
  logic        hold_q;      // Hold both counters at zero
  logic        pwm_mode_q;  // Pwm mode
  logic [20:0] mctrl_q;     // Three action bits per match
  logic [5:0]  out_en_q;    // Pwm output enables
  logic [5:0]  dbl_q;       // Double edge select, bit 0 unused
  logic [6:0]  release_q;   // Released, not yet applied
  logic [6:0]  status_q;    // Sticky match events
  logic [6:0]  int_en_q;    // Interrupt enables
  logic [5:0]  pwm_q;       // Pin drivers
  logic [31:0] rdata_q;     // Read data

  logic        tick;        // Counter advances this cycle
  logic [6:0]  hit;         // Counter equals active match
  logic [6:0]  ev;          // Match event on a tick
  logic [6:0]  ev_rst;      // Events that zero the counter
  logic [6:0]  ev_stop;     // Events that halt the counter
  logic [6:0]  ev_int;      // Events that set status
  logic        apply;       // Cycle boundary in pwm mode
  logic [6:0]  mwr;         // Write strobe per match channel
  logic [31:0] shadow [7];  // Software view of matches
  logic [31:0] active [7];  // Live compare values
  logic        wr_ctrl;
  logic        wr_count;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign wr_ctrl  = req_i.wr && (req_i.addr == OFS_CTRL);
  assign wr_count = req_i.wr && (req_i.addr == OFS_COUNT);

  // Control bits; a halt match clears run unless software writes it now
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q      <= 1'b0;
      hold_q     <= 1'b0;
      pwm_mode_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q      <= req_i.wdata[CTRL_RUN];
      hold_q     <= req_i.wdata[CTRL_HOLD];
      pwm_mode_q <= req_i.wdata[CTRL_PWM];
    end else if (|ev_stop) begin
      run_q      <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_lim_q <= RST_WORD;
      mctrl_q   <= '0;
      out_en_q  <= '0;
      dbl_q     <= '0;
      int_en_q  <= '0;
    end else if (req_i.wr) begin
      case (req_i.addr)
        OFS_PRE_LIM: pre_lim_q <= req_i.wdata;
        OFS_MCTRL:   mctrl_q   <= req_i.wdata[20:0];
        OFS_INT_EN:  int_en_q  <= req_i.wdata[6:0];
        OFS_PWMCFG: begin
          out_en_q <= req_i.wdata[5:0];
          // Output 1 has no partner match below it, single edge only
          dbl_q    <= {req_i.wdata[PC_DBL+5:PC_DBL+1], 1'b0};
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  // Tick when the prescaler sits at its limit; limit zero counts every cycle
  assign tick = run_q && !hold_q && (pre_cnt_q == pre_lim_q);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_cnt_q <= RST_WORD;
    end else if (hold_q || tick) begin
      pre_cnt_q <= RST_WORD;
    end else if (run_q) begin
      pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
    end
  end

  // Counter: zero on a reset action, else step on each tick
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= RST_WORD;
    end else if (hold_q) begin
      count_q <= RST_WORD;
    end else if (wr_count) begin
      count_q <= req_i.wdata;
    end else if (|ev_rst) begin
      count_q <= RST_WORD;
    end else if (tick) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Match channels and actions
  // ----------------------------------------------------------------
  // Every match value is a full 32-bit compare, so any width or period fits
  genvar gm;
  generate
    for (gm = 0; gm < 7; gm++) begin : g_match
      assign mwr[gm] = req_i.wr && (req_i.addr == OFS_MATCH0 + 8'(gm) * OFS_MSTEP);
      mpt_match_chan u_chan (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .wr_i      (mwr[gm]),
        .wdata_i   (req_i.wdata),
        .direct_i  (!pwm_mode_q),
        .load_i    (apply && release_q[gm]),
        .count_i   (count_q),
        .shadow_o  (shadow[gm]),
        .active_o  (active[gm]),
        .hit_o     (hit[gm])
      );
      assign ev[gm]      = tick && hit[gm];
      assign ev_int[gm]  = ev[gm] && mctrl_q[gm*MC_W+MC_INT];
      assign ev_stop[gm] = ev[gm] && mctrl_q[gm*MC_W+MC_STOP];
      // In pwm mode the cycle match always closes the period
      if (gm == 0) begin : g_cyc
        assign ev_rst[gm] = ev[gm] && (mctrl_q[MC_RST] || pwm_mode_q);
      end else begin : g_oth
        assign ev_rst[gm] = ev[gm] && mctrl_q[gm*MC_W+MC_RST];
      end
    end
  endgenerate

  // Cycle boundary: the one moment new edges can go live without a glitch
  assign apply = pwm_mode_q && ev[0];

  // Release bits: software set wins over the clear at apply time
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      release_q <= '0;
    end else begin
      release_q <= (release_q & ~({7{apply}}))
                 | ((req_i.wr && req_i.addr == OFS_RELEASE) ? req_i.wdata[6:0] : 7'h00);
    end
  end

  // ----------------------------------------------------------------
  // Pwm outputs
  // ----------------------------------------------------------------
  // Output k+1 falls on match k+1; it rises on the cycle match, or on
  // match k when double edge. Fall wins a tie, giving constant low.
  genvar gp;
  generate
    for (gp = 0; gp < 6; gp++) begin : g_pwm
      logic rise;
      logic fall;
      assign rise = dbl_q[gp] ? ev[gp] : ev[0];
      assign fall = ev[gp+1];
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          pwm_q[gp] <= 1'b0;
        end else if (!pwm_mode_q || !out_en_q[gp]) begin
          pwm_q[gp] <= 1'b0;
        end else if (fall) begin
          pwm_q[gp] <= 1'b0;
        end else if (rise) begin
          pwm_q[gp] <= 1'b1;
        end
      end
    end
  endgenerate

  assign pwm_o = pwm_q;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // New events win over a clear landing in the same cycle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else if (req_i.wr && req_i.addr == OFS_INT_CLR) begin
      status_q <= (status_q & ~req_i.wdata[6:0]) | ev_int;
    end else begin
      status_q <= status_q | ev_int;
    end
  end

  assign irq_o = |(status_q & int_en_q);

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = RST_WORD;
    case (req_i.addr)
      OFS_INT_STAT: rd_mux = {25'h0, status_q};
      OFS_INT_EN:   rd_mux = {25'h0, int_en_q};
      OFS_CTRL: begin
        rd_mux[CTRL_RUN]  = run_q;
        rd_mux[CTRL_HOLD] = hold_q;
        rd_mux[CTRL_PWM]  = pwm_mode_q;
      end
      OFS_COUNT:    rd_mux = count_q;
      OFS_PRE_LIM:  rd_mux = pre_lim_q;
      OFS_PRE_CNT:  rd_mux = pre_cnt_q;
      OFS_MCTRL:    rd_mux = {11'h0, mctrl_q};
      OFS_PWMCFG:   rd_mux = {18'h0, dbl_q, 2'h0, out_en_q};
      OFS_RELEASE:  rd_mux = {25'h0, release_q};
      default: begin
        for (int k = 0; k < 7; k++) begin
          if (req_i.addr == OFS_MATCH0 + 8'(k) * OFS_MSTEP) begin
            rd_mux = shadow[k];
          end
        end
      end
    endcase
  end

  // Data only in the cycle after the read, zero otherwise
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= req_i.rd ? rd_mux : RST_WORD;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // A tick with no action and no software touch steps the counter by one
  sequence s_plain_tick;
    tick && !(|ev_rst) && !wr_count && !hold_q;
  endsequence

  // Cycle boundary with a pending release on match 1
  sequence s_release1;
    apply && release_q[1] && !mwr[1]
      && !(req_i.wr && req_i.addr == OFS_RELEASE && req_i.wdata[1]);
  endsequence

  a_cycle_wrap: assert property (
    pwm_mode_q && ev[0] && !hold_q && !wr_count |=> count_q == RST_WORD)
    else $error("counter did not wrap on cycle match");

  a_count_step: assert property (
    s_plain_tick |=> count_q == $past(count_q) + 32'h0000_0001)
    else $error("counter did not step on tick");

  a_pre_limit: assert property (
    run_q && !hold_q && !tick && !wr_count
      |=> pre_cnt_q == $past(pre_cnt_q) + 32'h0000_0001 && $stable(count_q))
    else $error("prescaler or counter moved wrongly between ticks");

  a_stop_halts: assert property (
    (|ev_stop) && !wr_ctrl |=> !run_q ##1 $stable(count_q))
    else $error("halt match left the counter running");

  a_single_rise: assert property (
    pwm_mode_q && out_en_q[0] && ev[0] && !ev[1] && !wr_ctrl |=> pwm_q[0])
    else $error("single edge output did not rise at cycle start");

  a_edge_fall: assert property (
    ev[1] |=> !pwm_q[0])
    else $error("output 1 did not fall on its edge match");

  a_double_rise: assert property (
    pwm_mode_q && dbl_q[3] && out_en_q[3] && ev[3] && !ev[4] && !wr_ctrl
      |=> pwm_q[3])
    else $error("double edge output did not rise on its rise match");

  a_timer_quiet: assert property (
    !pwm_mode_q |=> pwm_o == 6'h00)
    else $error("pwm pin active outside pwm mode");

  a_release_load: assert property (
    s_release1 |=> active[1] == $past(shadow[1]) && !release_q[1])
    else $error("released match not applied at cycle reset");

  a_event_sticky: assert property (
    ev_int[0] |=> status_q[0])
    else $error("match event lost from status");

  // Only a clear of that bit may drop a set status bit
  a_status_hold: assert property (
    status_q[0] && !(req_i.wr && req_i.addr == OFS_INT_CLR && req_i.wdata[0])
      |=> status_q[0])
    else $error("status bit dropped without a clear");

endmodule : mpt_top

//--- core/mpt_pkg.sv
// Package for the match based pwm timer: register map, field positions,
// reset values and the register request carrier.
// Assumes a single peripheral clock and a plain one-cycle register port.
package mpt_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned MPT_NMATCH = 7;   // Match registers
  localparam int unsigned MPT_NPWM   = 6;   // Pinned pwm outputs
  localparam int unsigned MPT_AW     = 8;   // Register address width
  localparam int unsigned MPT_DW     = 32;  // Counter and data width

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INT_STAT = 8'h00; // Sticky match events, RO
  localparam logic [7:0] OFS_INT_CLR  = 8'h04; // Write one to clear, WO
  localparam logic [7:0] OFS_INT_EN   = 8'h08; // Interrupt enables
  localparam logic [7:0] OFS_CTRL     = 8'h0c; // Run, hold, pwm mode
  localparam logic [7:0] OFS_COUNT    = 8'h10; // Timer counter
  localparam logic [7:0] OFS_PRE_LIM  = 8'h14; // Prescale limit
  localparam logic [7:0] OFS_PRE_CNT  = 8'h18; // Prescale counter, RO
  localparam logic [7:0] OFS_MCTRL    = 8'h1c; // Match actions
  localparam logic [7:0] OFS_MATCH0   = 8'h20; // Cycle match register
  localparam logic [7:0] OFS_MSTEP    = 8'h04; // Stride of match regs
  localparam logic [7:0] OFS_PWMCFG   = 8'h3c; // Output enable, edge mode
  localparam logic [7:0] OFS_RELEASE  = 8'h40; // Release new match values

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RUN  = 0;  // Counter enable
  localparam int unsigned CTRL_HOLD = 1;  // Hold counters at zero
  localparam int unsigned CTRL_PWM  = 3;  // Pwm mode enable
  localparam int unsigned MC_INT    = 0;  // Per match: raise event
  localparam int unsigned MC_RST    = 1;  // Per match: zero counter
  localparam int unsigned MC_STOP   = 2;  // Per match: halt counter
  localparam int unsigned MC_W      = 3;  // Bits per match
  localparam int unsigned PC_DBL    = 8;  // Double edge select field

  localparam logic [31:0] RST_WORD = 32'h0000_0000; // Reset of words

  // Register port request, one cycle per access
  typedef struct packed {
    logic [7:0]  addr;   // Byte address
    logic [31:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } mpt_req_s;

endpackage : mpt_pkg

//--- core/mpt_match_chan.sv
// One match channel: software shadow, active compare value, comparator.
// Assumes the parent decides when a released value may be applied.
`timescale 1ns/1ps
module mpt_match_chan (
  input  wire logic        clock_i,   // Peripheral clock
  input  wire logic        sys_rst_i, // Async reset, high
  input  wire logic        wr_i,      // Software write to this match
  input  wire logic [31:0] wdata_i,   // Written value
  input  wire logic        direct_i,  // Timer mode: write goes live
  input  wire logic        load_i,    // Copy shadow to active
  input  wire logic [31:0] count_i,   // Current counter value
  output logic      [31:0] shadow_o,  // Value software sees
  output logic      [31:0] active_o,  // Value in use
  output logic             hit_o      // Counter equals active value
);
  import mpt_pkg::*;

  logic [31:0] shadow_q;
  logic [31:0] active_q;

  // ----------------------------------------------------------------
  // Shadow and active copies
  // ----------------------------------------------------------------
  // Shadow takes every write
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shadow_q <= RST_WORD;
    end else if (wr_i) begin
      shadow_q <= wdata_i;
    end
  end

  // Active only moves when allowed, so a cycle never sees a half update
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q <= RST_WORD;
    end else if (wr_i && direct_i) begin
      active_q <= wdata_i;
    end else if (load_i) begin
      active_q <= shadow_q;
    end
  end

  assign shadow_o = shadow_q;
  assign active_o = active_q;
  assign hit_o    = (count_i == active_q);

endmodule : mpt_match_chan

//--- tb/mpt_load.sv
// Load model for the pwm pins: counts rising edges seen on each pin.
// Assumes the pins are sampled on the peripheral clock.
`timescale 1ns/1ps
module mpt_load (
  input  wire logic             clock_i,   // Peripheral clock
  input  wire logic             sys_rst_i, // Async reset, high
  input  wire logic [5:0]       pwm_i,     // Pwm pins
  output logic      [5:0][15:0] rises_o    // Rising edges per pin
);
  logic [5:0] last_q; // Previous pin levels

  // Edge counting: a drive stage reacts to edges, so count those
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_q  <= 6'h00;
      rises_o <= '0;
    end else begin
      last_q <= pwm_i;
      for (int k = 0; k < 6; k++) begin
        if (pwm_i[k] && !last_q[k]) begin
          rises_o[k] <= rises_o[k] + 16'h0001;
        end
      end
    end
  end
endmodule : mpt_load

//--- tb/mpt_top_test.sv
// Testbench for the match based pwm timer: a cycle model in the bench is
// compared with read data, pins and interrupt on every clock.
// Assumes one 20 MHz clock and a master that never waits.
`timescale 1ns/1ps
module mpt_top_test;
  import mpt_pkg::*;
  logic clock_i, sys_rst_i;
  mpt_req_s req;
  logic [31:0] rdata_o;
  logic [5:0] pwm_o;
  logic irq_o;
  logic [5:0][15:0] rises;
  int errors, n_checks, i;
  logic [7:0] seed;
  // Model state
  logic [31:0] m_sh[7], m_ac[7], m_cnt, m_pre, m_lim, m_mc, m_cfg, m_rd;
  logic [6:0] m_st, m_en, m_rel, ev;
  logic [3:0] m_ctl;
  logic [5:0] m_q, m_pwm;
  int m_rise[6];

  mpt_top i_mpt_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req),
                     .rdata_o(rdata_o), .pwm_o(pwm_o), .irq_o(irq_o));
  mpt_load i_mpt_load (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pwm_i(pwm_o),
                       .rises_o(rises));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Cycle model; reads see values from before the edge
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge sys_rst_i) begin : model
    logic tick, rs, sp;
    mpt_req_s r;
    r = req;
    if (sys_rst_i) begin
      m_cnt = 0; m_pre = 0; m_lim = 0; m_mc = 0; m_cfg = 0; m_rd = 0;
      m_st = 0; m_en = 0; m_rel = 0; m_ctl = 0; m_q = 0; m_pwm = 0;
      for (int n = 0; n < 7; n++) begin m_sh[n] = 0; m_ac[n] = 0; end
      for (int n = 0; n < 6; n++) m_rise[n] = 0;
    end else begin
      tick = m_ctl[0] && !m_ctl[1] && m_pre == m_lim;
      rs = 0;
      sp = 0;
      for (int n = 0; n < 7; n++) begin
        ev[n] = tick && m_cnt == m_ac[n];
        rs |= ev[n] && (m_mc[3*n+1] || (n == 0 && m_ctl[3]));
        sp |= ev[n] && m_mc[3*n+2];
      end
      m_rd = 0;
      if (r.rd) begin
        case (r.addr)
          8'h00: m_rd = m_st;
          8'h08: m_rd = m_en;
          8'h0c: m_rd = m_ctl;
          8'h10: m_rd = m_cnt;
          8'h14: m_rd = m_lim;
          8'h18: m_rd = m_pre;
          8'h1c: m_rd = m_mc;
          8'h3c: m_rd = m_cfg;
          8'h40: m_rd = m_rel;
          default: if (r.addr >= 8'h20 && r.addr <= 8'h38 && r.addr[1:0] == 0)
            m_rd = m_sh[(r.addr - 8'h20) >> 2];
        endcase
      end
      // Fall wins a tie, so an edge equal to the cycle match keeps a single output low
      // Timer mode or a disabled output holds the pin low, no stale level
      for (int n = 0; n < 6; n++) begin
        if (!m_ctl[3] || !m_cfg[n]) m_q[n] = 1'b0;
        else if (ev[n+1]) m_q[n] = 1'b0;
        else if (m_cfg[8+n] ? ev[n] : ev[0]) m_q[n] = 1'b1;
      end
      for (int n = 0; n < 6; n++) if (m_ctl[3] && m_cfg[n] && m_q[n] && !m_pwm[n])
        m_rise[n]++;
      m_pwm = m_q;
      for (int n = 0; n < 7; n++) m_st[n] = m_st[n] && !(r.wr && r.addr == 8'h04
        && r.wdata[n]) || ev[n] && m_mc[3*n];
      if (ev[0] && m_ctl[3]) begin
        for (int n = 0; n < 7; n++) if (m_rel[n]) m_ac[n] = m_sh[n];
        m_rel = 0;
      end
      if (m_ctl[0] && !m_ctl[1]) m_pre = tick ? 0 : m_pre + 1;
      if (m_ctl[1]) begin m_cnt = 0; m_pre = 0; end
      else if (r.wr && r.addr == 8'h10) m_cnt = r.wdata;
      else if (tick) m_cnt = rs ? 0 : m_cnt + 1;
      if (r.wr && r.addr == 8'h0c) m_ctl = r.wdata[3:0] & 4'hb;
      else if (sp) m_ctl[0] = 1'b0;
      if (r.wr) begin
        case (r.addr)
          8'h08: m_en = r.wdata[6:0];
          8'h14: m_lim = r.wdata;
          8'h1c: m_mc = r.wdata & 32'h001f_ffff;
          8'h3c: m_cfg = r.wdata & 32'h0000_3e3f;
          8'h40: m_rel |= r.wdata[6:0];
          default: if (r.addr >= 8'h20 && r.addr <= 8'h38 && r.addr[1:0] == 0) begin
            m_sh[(r.addr - 8'h20) >> 2] = r.wdata;
            if (!m_ctl[3]) m_ac[(r.addr - 8'h20) >> 2] = r.wdata;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  always @(negedge clock_i) begin
    if (!sys_rst_i) begin
      cmp("rdata", m_rd, rdata_o);
      cmp("pwm", {26'h0, m_pwm}, {26'h0, pwm_o});
      cmp("irq", {31'h0, |(m_st & m_en)}, {31'h0, irq_o});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock_i);
    req.rd <= 1'b0;
  endtask : rd

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    n_checks = 0;
    seed = 8'h0c;
    req = '0;
    sys_rst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i <= 'h44; i += 4) rd(i[7:0]);
    rd(8'h80);
    wr(OFS_INT_STAT, '1);
    wr(OFS_PRE_CNT, '1);
    rd(OFS_INT_STAT);
    rd(OFS_PRE_CNT);
    $display("test reset values done");
    // Timer mode: event, reset and stop actions behind a prescaler
    wr(OFS_PRE_LIM, 32'h2);
    wr(OFS_MATCH0 + 8'h04, 32'h3);
    wr(OFS_MATCH0 + 8'h08, 32'h6);
    wr(OFS_MCTRL, 32'h0000_00c8);
    wr(OFS_INT_EN, 32'h6);
    wr(OFS_CTRL, 32'h1);
    repeat (60) @(posedge clock_i);
    rd(OFS_INT_STAT);
    wr(OFS_INT_CLR, 32'h2);
    rd(OFS_INT_STAT);
    wr(OFS_MCTRL, 32'h0000_0100);
    repeat (40) @(posedge clock_i);
    rd(OFS_CTRL);
    rd(OFS_COUNT);
    wr(OFS_COUNT, 32'h55);
    wr(OFS_CTRL, 32'h3);
    repeat (5) @(posedge clock_i);
    rd(OFS_COUNT);
    $display("test timer actions done");
    // Pwm mode: singles, a one-tick pulse from an edge at zero, one positive and one negative pulse
    wr(OFS_CTRL, 32'h0);
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_PRE_LIM, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_MCTRL, 32'h1);
    wr(OFS_MATCH0, 32'h9);
    wr(OFS_MATCH0 + 8'h04, 32'h5);
    wr(OFS_MATCH0 + 8'h08, 32'h0);
    wr(OFS_MATCH0 + 8'h0c, 32'h2);
    wr(OFS_MATCH0 + 8'h10, 32'h7);
    wr(OFS_MATCH0 + 8'h14, 32'h8);
    wr(OFS_MATCH0 + 8'h18, 32'h3);
    wr(OFS_PWMCFG, 32'h0000_283f);
    wr(OFS_CTRL, 32'h9);
    repeat (40) @(posedge clock_i);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFS_MATCH0 + 8'h04, {24'h0, seed} % 32'h9);
      wr(OFS_MATCH0 + 8'h18, {29'h0, seed[2:0]});
      repeat (25) @(posedge clock_i);
      wr(OFS_RELEASE, 32'h42);
      rd(OFS_RELEASE);
      repeat (30) @(posedge clock_i);
      rd(OFS_RELEASE);
      wr(OFS_INT_CLR, 32'h1);
    end
    wr(OFS_MATCH0, 32'hf);
    wr(OFS_RELEASE, 32'h1);
    repeat (50) @(posedge clock_i);
    wr(OFS_CTRL, 32'h1);
    repeat (20) @(posedge clock_i);
    // Pins idle by now, so the load lag and edge races no longer matter
    for (i = 0; i < 6; i++) cmp("rises", m_rise[i], {16'h0, rises[i]});
    $display("test pwm outputs done");
    tally_and_finish();
  end
endmodule : mpt_top_test
